// ==== rtl/rx_uart.v ====
// serial receiver with two-entry buffer, status flags and receive-complete request
// assumes: 10 MHz clk_i; baud_div_i sets samples; global interrupt enable from outside
`timescale 1ns/10ps
`include "rx_defines.vh"

module rx_uart (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // register port
  input wire [1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // sample rate and global interrupt enable
  input wire [15:0] baud_div_i,
  input wire global_irq_en_i,
  // serial line
  input wire rxd_i,
  output reg pin_override_o,
  // interrupt request
  output reg rx_irq_o
);

  // ====================================================================
  // registers
  reg [7:0] control_q;
  reg [7:0] format_q;
  reg u2x_q;
  wire receiver_enable = control_q[`CT_RECEIVER_ENABLE];
  wire parity_enable_bit = format_q[`FM_PARITY_ENABLE_BIT];
  wire parity_odd_select = format_q[`FM_PARITY_ODD_SELECT];
  wire [1:0] char_size_select = format_q[`FM_CSZ_HI:`FM_CSZ_LO];
  wire nine_bit = control_q[2] & (&char_size_select);

  // ====================================================================
  // sample-rate enable
  reg [15:0] div_q;
  reg tick_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= `BAUD_DIV_RST;
      tick_q <= 1'b0;
    end else if (div_q == 16'h0000) begin
      div_q <= baud_div_i;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q - 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ====================================================================
  // line sampling
  wire rxd_s;
  rx_sync3 u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(rxd_i),
    .sync_o(rxd_s)
  );

  // ====================================================================
  // buffer
  reg [1:0] count_q;
  reg wptr_q;
  reg rptr_q;
  wire [`ENTRY_W-1:0] head;
  reg [`ENTRY_W-1:0] shift_entry_q;
  reg held_q;
  wire rd_data = rd_i && addr_i == `REG_DATA && count_q != 2'h0;
  wire push = held_q && (count_q != 2'h2 || rd_data);
  // a loss seen while this frame waited is flagged on it as it enters the buffer
  wire [`ENTRY_W-1:0] push_entry = {shift_entry_q[11], shift_entry_q[10] | overrun_pend_q,
    shift_entry_q[9:0]};

  rx_entry_mem u_mem (
    .clk_i(clk_i),
    .wr_i(push),
    .wr_addr_i(wptr_q),
    .wr_data_i(push_entry),
    .rd_addr_i(rptr_q),
    .rd_data_o()
  );

  // head kept in flops too, since status reads need it in the same cycle
  reg [`ENTRY_W-1:0] ent_q [0:1];
  assign head = ent_q[rptr_q];

  // ====================================================================
  // receive state machine
  localparam S_IDLE = 2'h0;
  localparam S_START = 2'h1;
  localparam S_BITS = 2'h2;
  localparam S_STOP = 2'h3;
  reg [1:0] state_q;
  reg [4:0] samp_q;
  reg [3:0] bit_q;
  reg [9:0] sh_q;
  reg [2:0] vote_q;
  reg overrun_pend_q;

  wire [4:0] nsamp = u2x_q ? `SAMP_D : `SAMP_N; // RULE_22
  wire [4:0] vfirst = u2x_q ? `VOTE_D : `VOTE_N;
  wire voted = (vote_q[0] & vote_q[1]) | (vote_q[0] & vote_q[2]) | (vote_q[1] & vote_q[2]);
  wire [3:0] dbits = {2'b00, char_size_select} + 4'd5 + {3'b000, nine_bit};
  wire [3:0] nbits = dbits + {3'b000, parity_enable_bit};
  wire at_end = tick_q && samp_q == nsamp;

  // data bits masked to frame length; upper bits zero for short frames
  reg [8:0] dmask; // RULE_25
  reg par_calc;
  integer i;
  always @* begin
    dmask = 9'h000;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < dbits) begin
        dmask[i] = 1'b1;
      end
    end
    par_calc = ^(sh_q[8:0] & dmask) ^ parity_odd_select; // RULE_14
  end
  wire par_bit = sh_q[dbits];
  wire pe_new = parity_enable_bit && (par_calc != par_bit); // RULE_15 RULE_16 RULE_17

  always @(posedge clk_i) begin
    if (rst_i || !receiver_enable) begin // RULE_18
      state_q <= S_IDLE;
      samp_q <= 5'd0;
      bit_q <= 4'd0;
      sh_q <= 10'h000;
      vote_q <= 3'b000;
      held_q <= 1'b0;
      shift_entry_q <= {`ENTRY_W{1'b0}};
      overrun_pend_q <= 1'b0;
      count_q <= 2'h0;
      wptr_q <= 1'b0;
      rptr_q <= 1'b0; // RULE_05
      ent_q[0] <= {`ENTRY_W{1'b0}};
      ent_q[1] <= {`ENTRY_W{1'b0}};
    end else begin
      if (push) begin
        held_q <= 1'b0;
        ent_q[wptr_q] <= push_entry; // RULE_02 RULE_12
        wptr_q <= ~wptr_q;
        overrun_pend_q <= 1'b0; // RULE_13
      end
      if (rd_data) begin
        rptr_q <= ~rptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, rd_data};
      if (tick_q && state_q != S_IDLE) begin
        samp_q <= (samp_q == nsamp) ? 5'd1 : samp_q + 5'd1;
        if (samp_q == vfirst) begin
          vote_q[0] <= rxd_s;
        end else if (samp_q == vfirst + 5'd1) begin
          vote_q[1] <= rxd_s;
        end else if (samp_q == vfirst + 5'd2) begin
          vote_q[2] <= rxd_s; // RULE_21
        end
      end
      case (state_q)
        S_IDLE: begin
          if (tick_q && !rxd_s) begin
            state_q <= S_START; // RULE_21
            samp_q <= 5'd2;
            if (held_q && count_q == 2'h2 && !rd_data) begin
              overrun_pend_q <= 1'b1; // RULE_12 RULE_26
            end
          end
        end
        S_START: begin
          if (tick_q && samp_q == vfirst + 5'd3) begin
            if (voted) begin
              state_q <= S_IDLE; // RULE_23
            end
          end else if (at_end) begin
            state_q <= S_BITS;
            bit_q <= 4'd0;
          end
        end
        S_BITS: begin
          if (at_end) begin
            sh_q[bit_q] <= voted;
            bit_q <= bit_q + 4'd1;
            if (bit_q + 4'd1 == nbits) begin
              state_q <= S_STOP;
            end
          end
        end
        S_STOP: begin
          // only first stop bit looked at, regardless of stop count RULE_11
          if (tick_q && samp_q == vfirst + 5'd3) begin
            state_q <= S_IDLE;
            if (!held_q) begin
              held_q <= 1'b1;
              // overrun flag travels with the frame that waited in the shift register during the loss RULE_13
              shift_entry_q <= {pe_new, overrun_pend_q, ~voted, sh_q[8:0] & dmask}; // RULE_24
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ====================================================================
  // register writes; error flag bits of status are not writable
  always @(posedge clk_i) begin
    if (rst_i) begin
      control_q <= `CONTROL_RST;
      format_q <= `FORMAT_RST;
      u2x_q <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        `REG_STATUS: u2x_q <= wdata_i[`ST_U2X]; // RULE_07 RULE_09
        `REG_CONTROL: control_q <= wdata_i & 8'hfd;
        `REG_FORMAT: format_q <= wdata_i;
        default: begin
        end
      endcase
    end
  end

  // ====================================================================
  // read data and outputs
  wire rx_complete_flag = count_q != 2'h0; // RULE_04
  wire [7:0] status_v;
  assign status_v = {rx_complete_flag, 2'b00, rx_complete_flag & head[9], rx_complete_flag & head[10],
    rx_complete_flag & head[11] & parity_enable_bit, u2x_q, 1'b0}; // RULE_10 RULE_17 RULE_03

  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      rx_irq_o <= 1'b0;
      pin_override_o <= 1'b0;
    end else begin
      rdata_o <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          `REG_DATA: rdata_o <= rx_complete_flag ? head[7:0] : 8'h00; // RULE_25
          `REG_STATUS: rdata_o <= status_v;
          `REG_CONTROL: rdata_o <= {control_q[7:2], rx_complete_flag & head[8], 1'b0}; // RULE_01
          `REG_FORMAT: rdata_o <= format_q;
          default: rdata_o <= 8'h00;
        endcase
      end
      // request follows the flag only; error flags never raise it RULE_08
      rx_irq_o <= control_q[`CT_RX_COMPLETE_IRQ_ENABLE] & global_irq_en_i & rx_complete_flag & receiver_enable; // RULE_06
      pin_override_o <= receiver_enable; // RULE_19
    end
  end

endmodule

// ==== rtl/rx_defines.vh ====
// constants for the serial receive block: register offsets, field positions, reset values
// assumes: included by the receive block files and their verification files
//
// What this block does
// [RULE_01] software reads the ninth bit before the data byte; data read advances buffer
// [RULE_02] every buffer entry keeps ninth bit and frame, overrun, parity flags with data
// [RULE_03] software reads the status register before the data location
// [RULE_04] receive-complete flag is one exactly while unread data sits in buffer
// [RULE_05] clearing receiver enable flushes buffer and zeroes receive-complete
// [RULE_06] interrupt request stays high while flag and its enable are set
// [RULE_07] status writes never change the frame, overrun or parity flags
// [RULE_08] the error flags raise no interrupt request
// [RULE_09] software writes zero into the error flag positions of status
// [RULE_10] frame error shows first stop bit of next readable frame, one if low
// [RULE_11] frame error ignores stop-bit-count setting; only first stop bit checked
// [RULE_12] overrun when buffer full, shift register holds frame, new start bit seen
// [RULE_13] overrun clears when a frame moves successfully into the buffer
// [RULE_14] parity checked only with enable bit set; odd select chooses odd or even
// [RULE_15] checker compares data parity with parity bit, stores result with entry
// [RULE_16] parity flag set only if entry failed while checking enabled; valid until read
// [RULE_17] parity flag reads zero while parity checking is disabled
// [RULE_18] disabling receiver acts at once, abandons reception, discards buffered data
// [RULE_19] while disabled the serial input pin returns to normal port use
// [RULE_20] software flushes by reading data until receive-complete clears
// [RULE_21] receiver resynchronises on each start bit and majority filters every bit
// [RULE_22] oversampling sixteen per bit normally, eight in double speed
// [RULE_23] start bit rejected as noise if two of three centre samples are high
// [RULE_24] frame error set when voted stop bit is zero
// [RULE_25] unused upper data bits of short frames read as zero
// [RULE_26] completed frame waits in shift register while buffer full; start bit overruns
`ifndef RX_DEFINES_VH
`define RX_DEFINES_VH

// register offsets
`define REG_DATA 2'h0
`define REG_STATUS 2'h1
`define REG_CONTROL 2'h2
`define REG_FORMAT 2'h3

// status fields
`define ST_RXC 7
`define ST_FE 4
`define ST_DOR 3
`define ST_PE 2
`define ST_U2X 1

// control fields
`define CT_RX_COMPLETE_IRQ_ENABLE 7
`define CT_RECEIVER_ENABLE 4
`define CT_RX_NINTH_BIT 1

// format fields
`define FM_PARITY_ENABLE_BIT 5
`define FM_PARITY_ODD_SELECT 4
`define FM_STOP_BIT_COUNT_SELECT 3
`define FM_CSZ_HI 2
`define FM_CSZ_LO 1

// reset values
`define STATUS_RST 8'h00
`define CONTROL_RST 8'h00
`define FORMAT_RST 8'h06
`define BAUD_DIV_RST 16'h0000

// sample positions inside a bit, counted from 1
`define SAMP_N 5'd16
`define SAMP_D 5'd8
`define VOTE_N 5'd8
`define VOTE_D 5'd4

// entry layout: {pe, dor, fe, b8, data[7:0]}
`define ENTRY_W 12

`endif

// ==== rtl/rx_entry_mem.v ====
// two-entry storage for received frames, registered read data
// assumes: single clock, writer never writes a full buffer
`timescale 1ns/10ps
`include "rx_defines.vh"

module rx_entry_mem (
  // clock
  input wire clk_i,
  // write side
  input wire wr_i,
  input wire wr_addr_i,
  input wire [`ENTRY_W-1:0] wr_data_i,
  // read side
  input wire rd_addr_i,
  output reg [`ENTRY_W-1:0] rd_data_o
);

  reg [`ENTRY_W-1:0] mem_q [0:1];

  always @(posedge clk_i) begin
    if (wr_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_q[rd_addr_i];
  end

endmodule

// ==== rtl/rx_sync3.v ====
// three-stage input synchroniser; output moves once stages two and three agree
// assumes: input asynchronous to clk_i
`timescale 1ns/10ps

module rx_sync3 (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // async in, clean out
  input wire async_i,
  output reg sync_o
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      sync_o <= 1'b1;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sync_o <= s3_q;
      end
    end
  end

endmodule

// ==== verification/rx_uart_asserts.sv ====
// checker for the serial receive block, watching only its top-level ports
// assumes: shadow copies of control and format track the register writes
`timescale 1ns/10ps
`include "rx_defines.vh"
module rx_uart_asserts (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // register port
  input wire [1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  // sample rate, global enable, serial line, request
  input wire [15:0] baud_div_i,
  input wire global_irq_en_i,
  input wire rxd_i,
  input wire pin_override_o,
  input wire rx_irq_o
);
  // ==========================================
  // shadow registers
  reg [7:0] ctl_q;
  reg [7:0] fmt_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= `CONTROL_RST;
      fmt_q <= `FORMAT_RST;
    end else if (wr_i && addr_i == `REG_CONTROL) begin
      ctl_q <= wdata_i;
    end else if (wr_i && addr_i == `REG_FORMAT) begin
      fmt_q <= wdata_i;
    end
  end
  wire rd_st = rd_i && addr_i == `REG_STATUS;
  wire rd_dat = rd_i && addr_i == `REG_DATA;
  wire wr_ctl = wr_i && addr_i == `REG_CONTROL;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // properties
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  chk_irq_global: assert property (!global_irq_en_i |=> !rx_irq_o)
    else $error("request while global enable low");
  chk_irq_enable: assert property (!ctl_q[`CT_RX_COMPLETE_IRQ_ENABLE] |=> !rx_irq_o)
    else $error("request while its enable low");
  chk_irq_holds: assert property (rx_irq_o && global_irq_en_i && ctl_q[`CT_RX_COMPLETE_IRQ_ENABLE]
    && ctl_q[`CT_RECEIVER_ENABLE] && !$past(rd_dat) |=> rx_irq_o)
    else $error("request dropped without a data read");
  chk_pin_release: assert property (wr_ctl && !wdata_i[`CT_RECEIVER_ENABLE] |-> ##[1:2] !pin_override_o)
    else $error("pin still owned after disable");
  chk_pin_owned: assert property (wr_ctl && wdata_i[`CT_RECEIVER_ENABLE] |-> ##[1:2] pin_override_o)
    else $error("pin not owned after enable");
  chk_flush_irq: assert property (wr_ctl && !wdata_i[`CT_RECEIVER_ENABLE] |-> ##2 !rx_irq_o)
    else $error("request survives disable");
  chk_flag_empty: assert property (rd_st && !ctl_q[`CT_RECEIVER_ENABLE] |=> !rdata_o[`ST_RXC])
    else $error("complete flag set while disabled");
  chk_data_empty: assert property (rd_dat && !ctl_q[`CT_RECEIVER_ENABLE] |=> rdata_o == 8'h00)
    else $error("data returned while disabled");
  chk_parity_off: assert property (rd_st && !fmt_q[`FM_PARITY_ENABLE_BIT] |=> !rdata_o[`ST_PE])
    else $error("parity flag set with checking off");
  cover property (rd_st ##1 rdata_o[`ST_RXC]);
  cover property ($rose(rx_irq_o));
  cover property (rd_st ##1 rdata_o[`ST_FE]);
endmodule

bind rx_uart rx_uart_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .baud_div_i(baud_div_i),
  .global_irq_en_i(global_irq_en_i), .rxd_i(rxd_i), .pin_override_o(pin_override_o),
  .rx_irq_o(rx_irq_o));

// ==== verification/rx_line_model.sv ====
// remote serial transmitter driving the receive line
// assumes: line idles high; bits change just after a rising clock edge
`timescale 1ns/10ps
module rx_line_model (
  // clock
  input wire clk_i,
  // serial line
  output reg line_o
);
  initial line_o = 1'b1;
  // start, n data bits lsb first, optional parity, one stop, then an idle bit
  task send(input [8:0] d, input integer n, input pen, input pb, input stop,
            input integer spb);
    integer i;
    begin
      @(posedge clk_i) line_o <= 1'b0;
      for (i = 0; i < n + pen + 2; i = i + 1) begin
        repeat (spb) @(posedge clk_i);
        line_o <= (i < n) ? d[i] : (i < n + pen) ? pb : (i == n + pen) ? stop : 1'b1;
      end
      repeat (spb) @(posedge clk_i);
    end
  endtask
  // short low pulse, too brief to pass the centre vote
  task glitch;
    begin
      @(posedge clk_i) line_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      line_o <= 1'b1;
    end
  endtask
endmodule

// ==== verification/uart_receive_buffer_status_bench.sv ====
// self-checking bench for the serial receive block
// assumes: baud_div_i 0 gives a sample every clock, so 16 clocks per bit
`timescale 1ns/10ps
`include "rx_defines.vh"
module uart_receive_buffer_status_bench;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [1:0] addr_i = 2'h0;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg global_irq_en_i = 1'b1;
  wire [7:0] rdata_o;
  wire rxd;
  wire pin_override_o;
  wire rx_irq_o;
  integer err_count = 0;
  integer comparisons = 0;
  integer i;
  always #50 clk_i = ~clk_i;
  rx_line_model tx (.clk_i(clk_i), .line_o(rxd));
  rx_uart dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .baud_div_i(16'h0000),
    .global_irq_en_i(global_irq_en_i), .rxd_i(rxd), .pin_override_o(pin_override_o),
    .rx_irq_o(rx_irq_o));
  // ==========================================
  // tasks
  task check(input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [1:0] a, input [7:0] e);
    begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check(rdata_o, e);
    end
  endtask
  task frame(input [8:0] d, input integer n, input pen, input pb, input stop);
    begin
      tx.send(d, n, pen, pb, stop, 16);
      repeat (4) @(posedge clk_i);
    end
  endtask
  task close_out;
    begin
      if (err_count == 0 && comparisons > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // ==========================================
  // tests
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(`REG_CONTROL, 8'h90);
    frame(9'h0a5, 8, 0, 0, 1);
    rd(`REG_STATUS, 8'h80);
    check({7'h0, rx_irq_o}, 8'h01);
    global_irq_en_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({7'h0, rx_irq_o}, 8'h00);
    global_irq_en_i <= 1'b1;
    rd(`REG_DATA, 8'ha5);
    rd(`REG_STATUS, 8'h00);
    check({7'h0, rx_irq_o}, 8'h00);
    // bad stop bit; status write must leave the error flags alone
    frame(9'h03c, 8, 0, 0, 0);
    wr(`REG_STATUS, 8'h00);
    rd(`REG_STATUS, 8'h90);
    rd(`REG_DATA, 8'h3c);
    wr(`REG_FORMAT, 8'h0e);
    frame(9'h05a, 8, 0, 0, 1);
    rd(`REG_STATUS, 8'h80);
    rd(`REG_DATA, 8'h5a);
    // even then odd checking, correct and wrong parity bit
    for (i = 0; i < 4; i = i + 1) begin
      wr(`REG_FORMAT, i[1] ? 8'h36 : 8'h26);
      frame(9'h001, 8, 1, ~(i[0] ^ i[1]), 1);
      rd(`REG_STATUS, i[0] ? 8'h84 : 8'h80);
      rd(`REG_DATA, 8'h01);
    end
    frame(9'h001, 8, 1, 1, 1);
    wr(`REG_FORMAT, 8'h06);
    rd(`REG_STATUS, 8'h80);
    rd(`REG_DATA, 8'h01);
    // four frames into two entries plus the shift holder
    frame(9'h011, 8, 0, 0, 1);
    frame(9'h022, 8, 0, 0, 1);
    frame(9'h033, 8, 0, 0, 1);
    frame(9'h044, 8, 0, 0, 1);
    rd(`REG_STATUS, 8'h80);
    rd(`REG_DATA, 8'h11);
    rd(`REG_STATUS, 8'h80);
    rd(`REG_DATA, 8'h22);
    rd(`REG_STATUS, 8'h88);
    rd(`REG_DATA, 8'h33);
    rd(`REG_STATUS, 8'h00);
    frame(9'h055, 8, 0, 0, 1);
    rd(`REG_STATUS, 8'h80);
    rd(`REG_DATA, 8'h55);
    wr(`REG_CONTROL, 8'h94);
    frame(9'h1a5, 9, 0, 0, 1);
    rd(`REG_CONTROL, 8'h96);
    rd(`REG_DATA, 8'ha5);
    wr(`REG_CONTROL, 8'h90);
    wr(`REG_FORMAT, 8'h00);
    frame(9'h0ff, 5, 0, 0, 1);
    rd(`REG_DATA, 8'h1f);
    wr(`REG_FORMAT, 8'h06);
    wr(`REG_STATUS, 8'h02);
    tx.send(9'h0c3, 8, 0, 0, 1, 8);
    repeat (4) @(posedge clk_i);
    rd(`REG_STATUS, 8'h82);
    rd(`REG_DATA, 8'hc3);
    wr(`REG_STATUS, 8'h00);
    tx.glitch;
    repeat (40) @(posedge clk_i);
    rd(`REG_STATUS, 8'h00);
    // disable with one frame buffered and another mid-flight
    frame(9'h077, 8, 0, 0, 1);
    fork
      tx.send(9'h066, 8, 0, 0, 1, 16);
      begin
        repeat (60) @(posedge clk_i);
        wr(`REG_CONTROL, 8'h80);
      end
    join
    check({7'h0, pin_override_o}, 8'h00);
    rd(`REG_STATUS, 8'h00);
    wr(`REG_CONTROL, 8'h90);
    repeat (4) @(posedge clk_i);
    rd(`REG_STATUS, 8'h00);
    rd(`REG_DATA, 8'h00);
    close_out;
  end
  // a hang is cut well past the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count = err_count + 1;
    close_out;
  end
endmodule
